// ==== src/radio_cfg_pkg.sv ====
// Constants shared by the radio configuration and status register slice.
// Assumes a 10 MHz system clock and a host that reaches the registers over SPI.
package radio_cfg_pkg;
   // Clock and retry gap timing
   localparam int unsigned CLK_FREQ_MHZ = 10;
   localparam int unsigned RETRY_UNIT_US = 250;
   localparam int unsigned RETRY_UNIT_CYCLES = RETRY_UNIT_US * CLK_FREQ_MHZ;

   // Register offsets
   localparam logic [4:0] OFS_IRQ_MASK = 5'h00;
   localparam logic [4:0] OFS_PIPE_EN = 5'h02;
   localparam logic [4:0] OFS_ADDR_WIDTH = 5'h03;
   localparam logic [4:0] OFS_RETRANSMIT = 5'h04;
   localparam logic [4:0] OFS_CHANNEL = 5'h05;
   localparam logic [4:0] OFS_RADIO_SETUP = 5'h06;
   localparam logic [4:0] OFS_STATUS = 5'h07;

   // Command byte layout
   localparam int unsigned CMD_WRITE_POS = 5;
   localparam logic [2:0] CMD_READ_OP = 3'h0;
   localparam logic [2:0] CMD_WRITE_OP = 3'h1;

   // Field positions
   localparam int unsigned MASK_LSB = 4;
   localparam int unsigned FLAG_LSB = 4;
   localparam int unsigned GAP_LSB = 4;
   localparam int unsigned PIPE_NO_LSB = 1;
   localparam int unsigned FLAG_RETRY = 0;
   localparam int unsigned FLAG_SENT = 1;
   localparam int unsigned FLAG_RECV = 2;
   localparam int unsigned RF_GAIN_POS = 0;
   localparam int unsigned OUTPUT_POWER_SELECT_LSB = 1;
   localparam int unsigned RF_RATE_POS = 3;
   localparam int unsigned RF_PLL_POS = 4;

   // Reset values
   localparam logic [2:0] RST_IRQ_MASK = 3'h0;
   localparam logic [3:0] RST_PIPE_EN = 4'h3;
   localparam logic [1:0] RST_ADDR_WIDTH = 2'h3;
   localparam logic [7:0] RST_RETRANSMIT = 8'h03;
   localparam logic [6:0] RST_CHANNEL = 7'h02;
   localparam logic [4:0] RST_RADIO_SETUP = 5'h0f;
   localparam logic [2:0] RST_PIPE_NO = 3'h7;

   // Address width codes and empty pipe number code
   localparam logic [1:0] AW_ILLEGAL = 2'h0;
   localparam logic [1:0] AW_3_BYTES = 2'h1;
   localparam logic [1:0] AW_4_BYTES = 2'h2;
   localparam logic [1:0] AW_5_BYTES = 2'h3;
   localparam logic [2:0] PIPE_NO_EMPTY = 3'h7;

   // SPI frame
   localparam logic [4:0] BITS_CMD = 5'h08;
   localparam logic [4:0] BITS_DATA = 5'h10;

   typedef enum logic [1:0] {
      RT_IDLE = 2'b00,
      RT_WAIT_ACK = 2'b01,
      RT_GAP = 2'b10
   } retry_state_t;
endpackage

// ==== src/radio_config_status_regs.sv ====
// Configuration and status registers of the transceiver, reached over SPI,
// with the event flags, interrupt pin and the automatic retransmission timer.
// Assumes the radio core gives same-clock pulses for its events and that
// SPI pins arrive asynchronously, with SCK much slower than clk_sys_i.
//
// Overview of operation
// - Address width code: 00 illegal, 3/4/5 bytes.
// - One address width for all pipes.
// - Short widths use low address bytes only.
// - Retry gap is 250 us times code+1.
// - Retry count 1..15, zero disables, reset three.
// - Seven-bit channel field, resets to two.
// - Two-bit output power, -18 to 0 dBm.
// - Status shifts out during command byte.
// - Receive flag set on new payload.
// - Sent flag set after transmit or ack.
// - Retry limit flag halts until cleared.
// - Event flags clear only on written one.
// - Pipe number field, 111 when empty.
// - Status bit zero shows transmit FIFO full.
// - Interrupt pin low while unmasked flag set.
// - Mask bits block the pin, not flags, default unmasked.
`timescale 1ns/1ps
module radio_config_status_regs
   import radio_cfg_pkg::*;
#(
   parameter int unsigned RETRY_UNIT_CYC = RETRY_UNIT_CYCLES
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // SPI and interrupt pins
   input wire logic spi_csn_i,
   input wire logic spi_sck_i,
   input wire logic spi_mosi_i,
   output logic spi_miso_o,
   output logic spi_miso_oe_o,
   output logic irq_n_o,
   // Radio core events and state
   input wire logic rx_payload_arrived_i,
   input wire logic [2:0] rx_pipe_no_i,
   input wire logic rx_fifo_empty_i,
   input wire logic tx_fifo_full_i,
   input wire logic auto_ack_en_i,
   input wire logic tx_end_i,
   input wire logic ack_received_i,
   input wire logic ack_timeout_i,
   output logic retransmit_start_o,
   output logic comm_halt_o,
   // Configuration to the radio core
   output logic [3:0] pipe_enable_o,
   output logic [2:0] addr_bytes_o,
   output logic [4:0] addr_byte_mask_o,
   output logic [3:0] retry_limit_o,
   output logic [6:0] channel_o,
   output logic air_rate_select_o,
   output logic [1:0] output_power_select_o,
   output logic receiver_gain_select_o,
   output logic pll_force_lock_o
);

   typedef struct packed {
      logic [2:0] csn_s;
      logic [2:0] sck_s;
      logic [2:0] mosi_s;
      logic csn_f;
      logic sck_f;
      logic mosi_f;
      logic [4:0] bit_cnt;
      logic [7:0] rx_sh;
      logic [7:0] tx_sh;
      logic [7:0] cmd;
      logic miso;
      logic [2:0] mask;
      logic [3:0] pipe_en;
      logic [1:0] aw;
      logic [7:0] retr;
      logic [6:0] ch;
      logic [4:0] rf;
      logic [2:0] flags;
      logic [2:0] pipe_no;
      logic tx_full;
      logic irq_n;
      logic [2:0] addr_bytes;
      logic [4:0] addr_mask;
      retry_state_t rt_state;
      logic [3:0] retry_used;
      logic [19:0] gap_cnt;
      logic retransmit;
   } state_t;

   state_t st_q;
   state_t st_d;

   logic [7:0] status_byte;
   logic [7:0] read_data;
   logic [19:0] gap_target;
   logic gap_done;
   logic sck_rise;
   logic csn_fall;
   logic wr_status;
   logic [2:0] clr_flags;
   logic [2:0] set_flags;
   logic [7:0] wr_data;

   // Pipe number reads as empty whenever the receive FIFO holds nothing
   assign status_byte = {1'b0, st_q.flags, st_q.pipe_no, st_q.tx_full};

   always_comb begin
      read_data = 8'h00;
      case (st_q.cmd[4:0])
         OFS_IRQ_MASK: read_data = {1'b0, st_q.mask, 4'h0};
         OFS_PIPE_EN: read_data = {4'h0, st_q.pipe_en};
         OFS_ADDR_WIDTH: read_data = {6'h00, st_q.aw};
         OFS_RETRANSMIT: read_data = st_q.retr;
         OFS_CHANNEL: read_data = {1'b0, st_q.ch};
         OFS_RADIO_SETUP: read_data = {3'h0, st_q.rf};
         OFS_STATUS: read_data = status_byte;
         default: read_data = 8'h00;
      endcase
   end

   assign gap_target = (20'(st_q.retr[7:GAP_LSB]) + 20'h00001) * 20'(RETRY_UNIT_CYC);
   assign gap_done = st_q.gap_cnt >= gap_target - 20'h00001;

   always_comb begin
      st_d = st_q;
      sck_rise = 1'b0;
      csn_fall = 1'b0;
      wr_status = 1'b0;
      clr_flags = 3'h0;
      set_flags = 3'h0;
      wr_data = {st_q.rx_sh[6:0], st_q.mosi_f};

      // Three-stage pin sampling; the filtered level follows once stages two and three agree
      st_d.csn_s = {st_q.csn_s[1:0], spi_csn_i};
      st_d.sck_s = {st_q.sck_s[1:0], spi_sck_i};
      st_d.mosi_s = {st_q.mosi_s[1:0], spi_mosi_i};
      if (st_q.csn_s[2] == st_q.csn_s[1]) begin
         st_d.csn_f = st_q.csn_s[2];
      end
      if (st_q.sck_s[2] == st_q.sck_s[1]) begin
         st_d.sck_f = st_q.sck_s[2];
      end
      if (st_q.mosi_s[2] == st_q.mosi_s[1]) begin
         st_d.mosi_f = st_q.mosi_s[2];
      end
      csn_fall = st_q.csn_f && !st_d.csn_f;
      sck_rise = !st_q.csn_f && !st_q.sck_f && st_d.sck_f;

      if (csn_fall) begin
         // Snapshot of status is what the host sees alongside its command byte
         st_d.bit_cnt = 5'h00;
         st_d.tx_sh = status_byte;
         st_d.miso = status_byte[7];
      end else if (sck_rise) begin
         st_d.rx_sh = wr_data;
         // MISO moves right after the sampling edge, so it is stable for the host's next edge
         st_d.tx_sh = {st_q.tx_sh[6:0], 1'b0};
         st_d.miso = st_q.tx_sh[6];
         if (st_q.bit_cnt != 5'h1f) begin
            st_d.bit_cnt = st_q.bit_cnt + 5'h01;
         end
         if (st_q.bit_cnt + 5'h01 == BITS_CMD) begin
            st_d.cmd = wr_data;
            // Read data is loaded once the command is known
            if (wr_data[7:CMD_WRITE_POS] == CMD_READ_OP) begin
               st_d.tx_sh = 8'h00;
               st_d.miso = 1'b0;
            end
         end
         if (st_q.bit_cnt + 5'h01 == BITS_DATA && st_q.cmd[7:CMD_WRITE_POS] == CMD_WRITE_OP) begin
            case (st_q.cmd[4:0])
               OFS_IRQ_MASK: st_d.mask = wr_data[MASK_LSB +: 3];
               OFS_PIPE_EN: st_d.pipe_en = wr_data[3:0];
               OFS_ADDR_WIDTH: st_d.aw = wr_data[1:0];
               OFS_RETRANSMIT: st_d.retr = wr_data;
               OFS_CHANNEL: st_d.ch = wr_data[6:0];
               OFS_RADIO_SETUP: st_d.rf = wr_data[4:0];
               OFS_STATUS: wr_status = 1'b1;
               default: wr_status = 1'b0;
            endcase
         end
      end
      // Load read data one system cycle after the command byte lands
      if (!st_q.csn_f && !sck_rise && st_q.bit_cnt == BITS_CMD && st_q.cmd[7:CMD_WRITE_POS] == CMD_READ_OP
            && st_q.rx_sh == st_q.cmd && st_q.tx_sh == 8'h00 && !st_q.miso) begin
         st_d.tx_sh = read_data;
         st_d.miso = read_data[7];
      end

      if (wr_status) begin
         clr_flags = wr_data[FLAG_LSB +: 3];
      end

      // Retransmission engine
      st_d.retransmit = 1'b0;
      if (st_q.gap_cnt != 20'hfffff) begin
         st_d.gap_cnt = st_q.gap_cnt + 20'h00001;
      end
      case (st_q.rt_state)
         RT_IDLE: begin
            if (tx_end_i && !st_q.flags[FLAG_RETRY]) begin
               if (auto_ack_en_i) begin
                  st_d.rt_state = RT_WAIT_ACK;
                  st_d.gap_cnt = 20'h00000;
               end else begin
                  set_flags[FLAG_SENT] = 1'b1;
               end
            end
         end
         RT_WAIT_ACK: begin
            if (ack_received_i) begin
               set_flags[FLAG_SENT] = 1'b1;
               st_d.retry_used = 4'h0;
               st_d.rt_state = RT_IDLE;
            end else if (ack_timeout_i) begin
               if (st_q.retry_used >= st_q.retr[3:0]) begin
                  set_flags[FLAG_RETRY] = 1'b1;
                  st_d.retry_used = 4'h0;
                  st_d.rt_state = RT_IDLE;
               end else begin
                  st_d.rt_state = RT_GAP;
               end
            end
         end
         RT_GAP: begin
            if (gap_done) begin
               st_d.retransmit = 1'b1;
               st_d.retry_used = st_q.retry_used + 4'h1;
               st_d.rt_state = RT_IDLE;
            end
         end
         default: st_d.rt_state = RT_IDLE;
      endcase

      set_flags[FLAG_RECV] = rx_payload_arrived_i;
      // A set arriving with its clear keeps the flag
      st_d.flags = (st_q.flags & ~clr_flags) | set_flags;
      st_d.pipe_no = rx_fifo_empty_i ? PIPE_NO_EMPTY : rx_pipe_no_i;
      st_d.tx_full = tx_fifo_full_i;
      st_d.irq_n = ~|(st_d.flags & ~st_d.mask);

      if (!nrst_i) begin
         st_d = '0;
         st_d.csn_s = 3'h7;
         st_d.csn_f = 1'b1;
         st_d.mask = RST_IRQ_MASK;
         st_d.pipe_en = RST_PIPE_EN;
         st_d.aw = RST_ADDR_WIDTH;
         st_d.retr = RST_RETRANSMIT;
         st_d.ch = RST_CHANNEL;
         st_d.rf = RST_RADIO_SETUP;
         st_d.pipe_no = RST_PIPE_NO;
         st_d.irq_n = 1'b1;
         st_d.rt_state = RT_IDLE;
      end

      // Width decode is registered with its code; one width for every pipe and the transmit address
      case (st_d.aw)
         AW_3_BYTES: begin
            st_d.addr_bytes = 3'h3;
            st_d.addr_mask = 5'h07;
         end
         AW_4_BYTES: begin
            st_d.addr_bytes = 3'h4;
            st_d.addr_mask = 5'h0f;
         end
         AW_5_BYTES: begin
            st_d.addr_bytes = 3'h5;
            st_d.addr_mask = 5'h1f;
         end
         default: begin
            st_d.addr_bytes = 3'h0;
            st_d.addr_mask = 5'h00;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      st_q <= st_d;
   end

   assign addr_bytes_o = st_q.addr_bytes;
   assign addr_byte_mask_o = st_q.addr_mask;

   assign spi_miso_o = st_q.miso;
   assign spi_miso_oe_o = !st_q.csn_f;
   assign irq_n_o = st_q.irq_n;
   assign retransmit_start_o = st_q.retransmit;
   assign comm_halt_o = st_q.flags[FLAG_RETRY];
   assign pipe_enable_o = st_q.pipe_en;
   assign retry_limit_o = st_q.retr[3:0];
   assign channel_o = st_q.ch;
   assign air_rate_select_o = st_q.rf[RF_RATE_POS];
   assign output_power_select_o = st_q.rf[OUTPUT_POWER_SELECT_LSB +: 2];
   assign receiver_gain_select_o = st_q.rf[RF_GAIN_POS];
   // Test-only force; the host is expected to leave it at zero
   assign pll_force_lock_o = st_q.rf[RF_PLL_POS];

endmodule // radio_config_status_regs

// ==== tb/radio_regs_checker.sv ====
// Port-level assertions for the radio register slice.
// Assumes the top module's ports only; attached by the bind below.
`timescale 1ns/1ps
module radio_regs_checker #(
   parameter int unsigned RETRY_UNIT_CYC = 2500
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic spi_csn_i,
   input wire logic ack_timeout_i,
   input logic spi_miso_oe_o,
   input logic irq_n_o,
   input logic retransmit_start_o,
   input logic comm_halt_o,
   input logic [2:0] addr_bytes_o,
   input logic [4:0] addr_byte_mask_o,
   input logic [3:0] retry_limit_o,
   input logic [6:0] channel_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   a_halt_blocks_retry: assert property (comm_halt_o |-> !retransmit_start_o)
      else $error("retry started while halted");
   a_retry_one_cycle: assert property (retransmit_start_o |=> !retransmit_start_o)
      else $error("retry pulse too long");
   a_limit_zero_quiet: assert property (retry_limit_o == 4'h0 |-> !retransmit_start_o)
      else $error("retry with limit zero");
   a_halt_has_cause: assert property ($rose(comm_halt_o) |-> $past(ack_timeout_i) || $past(ack_timeout_i, 2))
      else $error("halt without ack failure");
   a_halt_holds_idle: assert property (comm_halt_o && !spi_miso_oe_o |=> comm_halt_o)
      else $error("halt cleared outside a frame");
   a_width_mask_match: assert property (addr_byte_mask_o == 5'((6'h1 << addr_bytes_o) - 6'h1))
      else $error("address mask disagrees with width");
   a_cfg_quiet_idle: assert property (!spi_miso_oe_o |=> $stable({channel_o, retry_limit_o, addr_bytes_o}))
      else $error("configuration changed outside a frame");
   a_miso_off_idle: assert property (spi_csn_i [*6] |-> !spi_miso_oe_o)
      else $error("miso driven while deselected");
   a_miso_on_frame: assert property (!spi_csn_i [*6] |-> spi_miso_oe_o)
      else $error("miso not driven in frame");
   c_retry: cover property (retransmit_start_o);
   c_halt: cover property ($rose(comm_halt_o));
   c_irq: cover property ($fell(irq_n_o));
endmodule // radio_regs_checker

bind radio_config_status_regs radio_regs_checker #(.RETRY_UNIT_CYC(RETRY_UNIT_CYC)) checker_i (
   .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .spi_csn_i(spi_csn_i), .ack_timeout_i(ack_timeout_i),
   .spi_miso_oe_o(spi_miso_oe_o), .irq_n_o(irq_n_o), .retransmit_start_o(retransmit_start_o),
   .comm_halt_o(comm_halt_o), .addr_bytes_o(addr_bytes_o), .addr_byte_mask_o(addr_byte_mask_o),
   .retry_limit_o(retry_limit_o), .channel_o(channel_o));

// ==== tb/spi_host_model.sv ====
// Host side of the SPI link, mode 0, one command and one data byte a frame.
// Assumes SCK half period of 4 system clocks, an 800 ns link clock period.
`timescale 1ns/1ps
module spi_host_model (
   input wire logic clk_sys_i,
   input wire logic spi_miso_i,
   output logic spi_csn_o,
   output logic spi_sck_o,
   output logic spi_mosi_o
);
   localparam int HALF = 4;
   initial begin
      spi_csn_o = 1'b1;
      spi_sck_o = 1'b0;
      spi_mosi_o = 1'b0;
   end
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] st, output logic [7:0] rd);
      logic [15:0] o;
      logic [15:0] i;
      o = {cmd, wd};
      @(posedge clk_sys_i);
      spi_csn_o <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      for (int k = 15; k >= 0; k--) begin
         spi_mosi_o <= o[k];
         repeat (HALF) @(posedge clk_sys_i);
         spi_sck_o <= 1'b1;
         i[k] = spi_miso_i;
         repeat (HALF) @(posedge clk_sys_i);
         spi_sck_o <= 1'b0;
      end
      repeat (HALF) @(posedge clk_sys_i);
      spi_csn_o <= 1'b1;
      // Idle data line shows the inverse so a stale bit cannot pass
      spi_mosi_o <= ~o[0];
      repeat (HALF) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      st = i[15:8];
      rd = i[7:0];
   endtask
endmodule // spi_host_model

// ==== tb/testbench.sv ====
// Self-checking bench for the radio register slice.
// Assumes the SPI host model and a retry unit shortened to 4 clocks.
`timescale 1ns/1ps
module testbench;
   import radio_cfg_pkg::*;
   localparam int unsigned UNIT = 4;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic csn, sck, mosi, miso, oe, irq_n, rts, halt, rate, gain, pll, miso_line;
   logic aa = 1'b0;
   logic full = 1'b0;
   logic empty = 1'b1;
   logic [3:0] ev_q = 4'h0;
   logic [2:0] pno = 3'h0;
   logic [3:0] pe, rl;
   logic [2:0] ab;
   logic [4:0] am;
   logic [6:0] ch;
   logic [1:0] pwr;
   logic [7:0] st, d, v;
   int err_count = 0;
   int cmp_count = 0;
   int n;
   always #50 clk_sys_i = ~clk_sys_i;
   // A deselected MISO reads inverted so a late or missing enable cannot pass unseen
   assign miso_line = oe ? miso : ~miso;
   spi_host_model host (.clk_sys_i(clk_sys_i), .spi_miso_i(miso_line), .spi_csn_o(csn), .spi_sck_o(sck),
      .spi_mosi_o(mosi));
   radio_config_status_regs #(.RETRY_UNIT_CYC(UNIT)) dut (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .spi_csn_i(csn), .spi_sck_i(sck), .spi_mosi_i(mosi),
      .spi_miso_o(miso), .spi_miso_oe_o(oe), .irq_n_o(irq_n), .rx_payload_arrived_i(ev_q[3]), .rx_pipe_no_i(pno),
      .rx_fifo_empty_i(empty), .tx_fifo_full_i(full), .auto_ack_en_i(aa), .tx_end_i(ev_q[2]),
      .ack_received_i(ev_q[1]), .ack_timeout_i(ev_q[0]), .retransmit_start_o(rts), .comm_halt_o(halt),
      .pipe_enable_o(pe), .addr_bytes_o(ab), .addr_byte_mask_o(am), .retry_limit_o(rl), .channel_o(ch),
      .air_rate_select_o(rate), .output_power_select_o(pwr), .receiver_gain_select_o(gain), .pll_force_lock_o(pll));
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] x);
      host.xfer({CMD_WRITE_OP, a}, x, st, d);
   endtask
   task automatic rd(input logic [4:0] a);
      host.xfer({CMD_READ_OP, a}, 8'h00, st, d);
   endtask
   task automatic pulse(input logic [3:0] w, input logic a);
      @(posedge clk_sys_i);
      ev_q <= w;
      aa <= a;
      @(posedge clk_sys_i);
      ev_q <= 4'h0;
      repeat (3) @(negedge clk_sys_i);
   endtask
   task automatic report_and_stop;
      if (err_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   function automatic logic [7:0] aw_bytes(input logic [1:0] c);
      return (c == AW_ILLEGAL) ? 8'h00 : 8'(c) + 8'h02;
   endfunction
   initial begin
      repeat (100000) @(posedge clk_sys_i);
      err_count++;
      report_and_stop();
   end
   initial begin
      void'($urandom(32'ha2f7898e));
      repeat (4) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      rd(OFS_RETRANSMIT);
      chk("retransmit reset", d, 8'h03);
      chk("status reset", st, 8'h0e);
      rd(5'h08);
      chk("unmapped read", d, 8'h00);
      rd(OFS_PIPE_EN);
      chk("pipe enable reset", d, 8'h03);
      v = 8'($urandom) & 8'h0f;
      wr(OFS_PIPE_EN, v);
      rd(OFS_PIPE_EN);
      chk("pipe enable", d, v);
      chk("pipe enable out", {4'h0, pe}, v);
      chk("channel reset", {1'b0, ch}, 8'h02);
      chk("radio reset", {3'h0, pll, rate, pwr, gain}, 8'h0f);
      for (int k = 0; k < 5; k++) begin
         logic [1:0] c;
         c = 2'(k + 3);
         if (k > 0)
            wr(OFS_ADDR_WIDTH, {6'h00, c});
         rd(OFS_ADDR_WIDTH);
         chk("width code", d, {6'h00, c});
         chk("address bytes", {5'h00, ab}, aw_bytes(c));
         chk("address mask", {3'h0, am}, 8'((9'h1 << aw_bytes(c)) - 9'h1));
      end
      for (int k = 0; k < 4; k++) begin
         v = 8'($urandom);
         wr(OFS_RETRANSMIT, v);
         rd(OFS_RETRANSMIT);
         chk("retransmit", d, v);
         chk("retry limit", {4'h0, rl}, {4'h0, v[3:0]});
         v = 8'($urandom) & 8'h7f;
         wr(OFS_CHANNEL, v);
         chk("channel", {1'b0, ch}, v);
         v = (8'($urandom) & 8'h09) | 8'(k << 1);
         wr(OFS_RADIO_SETUP, v);
         chk("radio setup", {3'h0, pll, rate, pwr, gain}, v);
      end
      for (int p = 0; p < 6; p++) begin
         @(posedge clk_sys_i);
         pno <= 3'(p);
         full <= p[0];
         empty <= 1'b0;
         rd(OFS_STATUS);
         chk("pipe and full", st, {4'h0, 3'(p), p[0]});
         chk("status read data", d, {4'h0, 3'(p), p[0]});
      end
      @(posedge clk_sys_i);
      empty <= 1'b1;
      pulse(4'h8, 1'b0);
      chk("irq on receive", {7'h0, irq_n}, 8'h00);
      wr(OFS_STATUS, 8'h00);
      chk("receive flag", st & 8'h70, 8'h40);
      wr(OFS_STATUS, 8'h40);
      chk("flag after zero", st & 8'h70, 8'h40);
      chk("irq released", {7'h0, irq_n}, 8'h01);
      wr(OFS_IRQ_MASK, 8'h40);
      rd(OFS_IRQ_MASK);
      chk("mask readback", d, 8'h40);
      pulse(4'h8, 1'b0);
      chk("masked irq", {7'h0, irq_n}, 8'h01);
      wr(OFS_STATUS, 8'h40);
      wr(OFS_IRQ_MASK, 8'h00);
      pulse(4'h4, 1'b0);
      wr(OFS_STATUS, 8'h20);
      chk("sent no ack", st & 8'h70, 8'h20);
      pulse(4'h4, 1'b1);
      rd(OFS_STATUS);
      chk("sent waits ack", st & 8'h70, 8'h00);
      pulse(4'h2, 1'b1);
      wr(OFS_STATUS, 8'h20);
      chk("sent on ack", st & 8'h70, 8'h20);
      wr(OFS_RETRANSMIT, 8'h11);
      @(posedge clk_sys_i);
      ev_q <= 4'h4;
      @(posedge clk_sys_i);
      ev_q <= 4'h1;
      @(posedge clk_sys_i);
      ev_q <= 4'h0;
      n = 1;
      while (rts !== 1'b1 && n < 100) begin
         @(negedge clk_sys_i);
         n++;
      end
      chk("retry gap", 8'(n >= 2 * UNIT - 2 && n <= 2 * UNIT + 3), 8'h01);
      if (n >= 100)
         report_and_stop();
      pulse(4'h4, 1'b1);
      pulse(4'h1, 1'b1);
      chk("halt at limit", {7'h0, halt}, 8'h01);
      chk("irq at limit", {7'h0, irq_n}, 8'h00);
      wr(OFS_STATUS, 8'h10);
      chk("halt cleared", {7'h0, halt}, 8'h00);
      wr(OFS_RETRANSMIT, 8'h00);
      pulse(4'h4, 1'b1);
      pulse(4'h1, 1'b1);
      chk("limit zero", {7'h0, halt}, 8'h01);
      wr(OFS_STATUS, 8'h10);
      report_and_stop();
   end
endmodule // testbench
